//--- som_defines.vh
// Constants for the signal output source mux and receiver select registers.
`ifndef SOM_DEFINES_VH
`define SOM_DEFINES_VH

// ------------------------------------------------------------
// Register byte addresses
// ------------------------------------------------------------
// Register word indices; the TXSRC and RXSEL byte addresses below are four times these indices.
`define SOM_IDX_TXSRC       8'h16
`define SOM_IDX_RXSEL       8'h17
`define SOM_ADDR_TXSRC      8'h58
`define SOM_ADDR_RXSEL      8'h5C
`define SOM_ADDR_TESTSEL    8'h60
`define SOM_ADDR_STATUS     8'h64
`define SOM_ADDR_CMD        8'h68

// ------------------------------------------------------------
// Reset values and field positions
// ------------------------------------------------------------
`define SOM_TXSRC_RST       8'h10
`define SOM_RXSEL_RST       8'h84
`define SOM_TESTSEL_RST     8'h00
`define SOM_TXSRC_MASK      8'h3F
`define SOM_SRC_MSB         3
`define SOM_SRC_LSB         0
`define SOM_UART_MSB        7
`define SOM_UART_LSB        6
`define SOM_WAIT_MSB        5
`define SOM_WAIT_LSB        0
`define SOM_TBSEL_MSB       2
`define SOM_TBSEL_LSB       0
`define SOM_CMD_RXMULT_BIT  2

// ------------------------------------------------------------
// Output source codes
// ------------------------------------------------------------
`define SOM_SRC_TRI         4'h0
`define SOM_SRC_LOW         4'h1
`define SOM_SRC_HIGH        4'h2
`define SOM_SRC_TBUS        4'h3
`define SOM_SRC_ENV         4'h4
`define SOM_SRC_TXSER       4'h5
`define SOM_SRC_RXOUT       4'h6
`define SOM_SRC_RXSER       4'h7
`define SOM_SRC_HS_RX       4'h8
`define SOM_SRC_HS_TX       4'h9
`define SOM_SRC_HS_CMP      4'hA
`define SOM_SRC_HS_RFU      4'hB
`define SOM_SRC_A_RX        4'hC
`define SOM_SRC_A_TX        4'hD
`define SOM_SRC_A_RXUF      4'hE
`define SOM_SRC_A_ENV       4'hF

// ------------------------------------------------------------
// Command codes written to the command register
// ------------------------------------------------------------
`define SOM_CMD_NONE        2'h0
`define SOM_CMD_TRANSCEIVE  2'h1
`define SOM_CMD_RECEIVE     2'h2
`define SOM_CMD_IDLE        2'h3

`endif

//--- som_signal_output_mux.v
// Signal output source mux with receiver select and receiver wait logic.
`timescale 1ns/10ps
`include "som_defines.vh"

module som_signal_output_mux #(
  parameter WAIT_W = 6
) (
  // Clock, reset and enable
  input  wire        ref_clk_i,
  input  wire        nrst_i,
  input  wire        clk_en_i,
  // AHB-Lite slave
  input  wire        hsel_i,
  input  wire [31:0] haddr_i,
  input  wire [1:0]  htrans_i,
  input  wire        hwrite_i,
  input  wire [2:0]  hsize_i,
  input  wire [31:0] hwdata_i,
  input  wire        hready_i,
  output wire [31:0] hrdata_o,
  output wire        hreadyout_o,
  output wire        hresp_o,
  // Internal sources for the output pin
  input  wire [7:0]  test_bus_i,
  input  wire        coder_env_i,
  input  wire        tx_serial_i,
  input  wire        rx_regen_i,
  input  wire        rx_serial_i,
  input  wire        hs_rx_i,
  input  wire        hs_tx_i,
  input  wire        hs_cmp_i,
  input  wire        a_rx_carrier_i,
  input  wire        a_tx_carrier_i,
  input  wire        a_rx_unfilt_i,
  input  wire        a_env_unfilt_i,
  // Transceiver events
  input  wire        tx_done_i,
  input  wire        bit_clk_i,
  input  wire        rx_frame_end_i,
  // Receive pin and UART feeds
  input  wire        rx_pin_i,
  input  wire        sig_in_env_i,
  input  wire        analog_mod_i,
  input  wire        sig_in_mod_i,
  output reg         uart_in_o,
  output reg         rx_data_o,
  output wire        rx_active_o,
  // Signal output pin
  output reg         signal_output_pin_o,
  output reg         signal_output_pin_oe_n_o
);

  // ------------------------------------------------------------
  // Local sizes
  // ------------------------------------------------------------
  localparam SRC_W  = 4;
  localparam USEL_W = 2;

  // ------------------------------------------------------------
  // Bus address phase capture
  // ------------------------------------------------------------
  reg        wr_pend_r;
  reg [7:0]  addr_r;
  reg [7:0]  txsrc_r;
  reg [7:0]  rxsel_r;
  reg [7:0]  testsel_r;
  reg        rx_mult_r;
  reg        rx_mode_r;
  reg        wait_mode_r;
  reg [WAIT_W-1:0] wait_cnt_r;
  reg        wait_busy_r;
  reg        use_wait_r;
  reg [31:0] rdata_r;
  reg        pin_nxt;
  reg        oe_n_nxt;
  reg        uart_nxt;

  wire       addr_ok = hsel_i & hready_i & htrans_i[1];
  wire       wr_now  = wr_pend_r;
  wire [1:0] cmd_w   = hwdata_i[1:0];
  wire [SRC_W-1:0]  src_w  = txsrc_r[`SOM_SRC_MSB:`SOM_SRC_LSB];
  wire [USEL_W-1:0] usel_w = rxsel_r[`SOM_UART_MSB:`SOM_UART_LSB];
  // Status word: wait busy, receive mode, receiver active, receive multiple.
  wire [3:0] status_w = {wait_busy_r, rx_mode_r, rx_active_o, rx_mult_r};

  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign hrdata_o    = rdata_r;
  assign rx_active_o = rx_mode_r & ~wait_busy_r;

  // Read decode shared by the read path; unmapped offsets read zero.
  function [31:0] rd_mux;
    input [7:0] a;
    begin
      if (a == `SOM_ADDR_TXSRC) begin
        rd_mux = {24'h000000, txsrc_r};
      end else if (a == `SOM_ADDR_RXSEL) begin
        rd_mux = {24'h000000, rxsel_r};
      end else if (a == `SOM_ADDR_TESTSEL) begin
        rd_mux = {24'h000000, testsel_r};
      end else if (a == `SOM_ADDR_STATUS) begin
        rd_mux = {28'h0000000, status_w};
      end else begin
        rd_mux = 32'h00000000;
      end
    end
  endfunction

  // Value a register will hold once the pending write lands.
  function [31:0] fwd_mux;
    input [7:0] a;
    input [7:0] d;
    begin
      if (a == `SOM_ADDR_TXSRC) begin
        fwd_mux = {24'h000000, d & `SOM_TXSRC_MASK};
      end else if ((a == `SOM_ADDR_RXSEL) || (a == `SOM_ADDR_TESTSEL)) begin
        fwd_mux = {24'h000000, d};
      end else begin
        fwd_mux = rd_mux(a);
      end
    end
  endfunction

  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      wr_pend_r <= 1'b0;
      addr_r    <= 8'h00;
      rdata_r   <= 32'h00000000;
      txsrc_r   <= `SOM_TXSRC_RST;
      rxsel_r   <= `SOM_RXSEL_RST;
      testsel_r <= `SOM_TESTSEL_RST;
      rx_mult_r <= 1'b0;
    end else if (clk_en_i) begin
      wr_pend_r <= addr_ok & hwrite_i;
      if (addr_ok) begin
        addr_r <= haddr_i[7:0];
      end
      // Read data is registered so it stands for the whole data phase.
      if (addr_ok & ~hwrite_i) begin
        if (wr_now && (addr_r == haddr_i[7:0])) begin
          // A read right behind a write to the same word must see the new value.
          rdata_r <= fwd_mux(addr_r, hwdata_i[7:0]);
        end else begin
          rdata_r <= rd_mux(haddr_i[7:0]);
        end
      end
      if (wr_now) begin
        if (addr_r == `SOM_ADDR_TXSRC) begin
          txsrc_r <= hwdata_i[7:0] & `SOM_TXSRC_MASK;
        end else if (addr_r == `SOM_ADDR_RXSEL) begin
          rxsel_r <= hwdata_i[7:0];
        end else if (addr_r == `SOM_ADDR_TESTSEL) begin
          testsel_r <= hwdata_i[7:0];
        end else if (addr_r == `SOM_ADDR_CMD) begin
          rx_mult_r <= hwdata_i[`SOM_CMD_RXMULT_BIT];
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Test bus bit pick
  // ------------------------------------------------------------
  // One-hot gating avoids a wide variable index on the test bus.
  wire [7:0] tbus_hit_w;
  wire       tbus_bit_w;
  genvar     gi;

  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_tbus
      localparam [2:0] BIT_IDX = gi;
      assign tbus_hit_w[gi] = test_bus_i[gi] &
                              (testsel_r[`SOM_TBSEL_MSB:`SOM_TBSEL_LSB] == BIT_IDX);
    end
  endgenerate

  assign tbus_bit_w = |tbus_hit_w;

  // ------------------------------------------------------------
  // Receive mode and receiver wait
  // ------------------------------------------------------------
  wire cmd_wr = wr_now & (addr_r == `SOM_ADDR_CMD);

  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      rx_mode_r   <= 1'b0;
      wait_mode_r <= 1'b0;
      use_wait_r  <= 1'b0;
      wait_cnt_r  <= {WAIT_W{1'b0}};
      wait_busy_r <= 1'b0;
    end else if (clk_en_i) begin
      if (cmd_wr && cmd_w == `SOM_CMD_TRANSCEIVE) begin
        wait_mode_r <= 1'b1;
        use_wait_r  <= 1'b1;
      end else if (cmd_wr && cmd_w == `SOM_CMD_RECEIVE) begin
        rx_mode_r   <= 1'b1;
        use_wait_r  <= 1'b0;
        wait_busy_r <= 1'b0;
      end else if (cmd_wr && cmd_w == `SOM_CMD_IDLE) begin
        rx_mode_r   <= 1'b0;
        wait_mode_r <= 1'b0;
        wait_busy_r <= 1'b0;
      end else if (wait_mode_r && tx_done_i) begin
        // Transmission over: enter receive and hold off for the wait count.
        wait_mode_r <= 1'b0;
        rx_mode_r   <= 1'b1;
        wait_cnt_r  <= rxsel_r[`SOM_WAIT_MSB:`SOM_WAIT_LSB];
        wait_busy_r <= use_wait_r & (rxsel_r[`SOM_WAIT_MSB:`SOM_WAIT_LSB] != 6'h00);
      end else if (wait_busy_r && bit_clk_i) begin
        if (wait_cnt_r == {{(WAIT_W-1){1'b0}}, 1'b1}) begin
          wait_busy_r <= 1'b0;
        end
        wait_cnt_r <= wait_cnt_r - {{(WAIT_W-1){1'b0}}, 1'b1};
      end else if (rx_mode_r && rx_frame_end_i && !rx_mult_r) begin
        // Receive multiple keeps the receiver armed after each frame.
        rx_mode_r <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // UART input select and gated receive pin
  // ------------------------------------------------------------
  always @* begin
    case (usel_w)
      2'h0: begin
        uart_nxt = 1'b0;
      end
      2'h1: begin
        uart_nxt = sig_in_env_i;
      end
      2'h2: begin
        uart_nxt = analog_mod_i;
      end
      default: begin
        uart_nxt = sig_in_mod_i;
      end
    endcase
  end

  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      uart_in_o <= 1'b0;
      rx_data_o <= 1'b0;
    end else if (clk_en_i) begin
      uart_in_o <= uart_nxt;
      rx_data_o <= rx_pin_i & rx_active_o;
    end
  end

  // ------------------------------------------------------------
  // Output source mux
  // ------------------------------------------------------------
  always @* begin
    oe_n_nxt = 1'b0;
    pin_nxt  = 1'b0;
    case (src_w)
      `SOM_SRC_TRI: begin
        // Data is parked low while released so no stale level leaks out.
        oe_n_nxt = 1'b1;
      end
      `SOM_SRC_LOW: begin
        pin_nxt = 1'b0;
      end
      `SOM_SRC_HIGH: begin
        pin_nxt = 1'b1;
      end
      `SOM_SRC_TBUS: begin
        pin_nxt = tbus_bit_w;
      end
      `SOM_SRC_ENV: begin
        pin_nxt = coder_env_i;
      end
      `SOM_SRC_TXSER: begin
        pin_nxt = tx_serial_i;
      end
      `SOM_SRC_RXOUT: begin
        pin_nxt = rx_regen_i & rx_active_o;
      end
      `SOM_SRC_RXSER: begin
        pin_nxt = rx_serial_i;
      end
      `SOM_SRC_HS_RX: begin
        pin_nxt = hs_rx_i & rx_active_o;
      end
      `SOM_SRC_HS_TX: begin
        pin_nxt = hs_tx_i;
      end
      `SOM_SRC_HS_CMP: begin
        pin_nxt = hs_cmp_i;
      end
      `SOM_SRC_HS_RFU: begin
        pin_nxt = 1'b0;
      end
      `SOM_SRC_A_RX: begin
        pin_nxt = a_rx_carrier_i & rx_active_o;
      end
      `SOM_SRC_A_TX: begin
        pin_nxt = a_tx_carrier_i;
      end
      `SOM_SRC_A_RXUF: begin
        pin_nxt = a_rx_unfilt_i;
      end
      default: begin
        pin_nxt = a_env_unfilt_i;
      end
    endcase
  end

  // A registered pin means a source change lands cleanly one clock later.
  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      signal_output_pin_o      <= 1'b0;
      signal_output_pin_oe_n_o <= 1'b1;
    end else if (clk_en_i) begin
      signal_output_pin_o      <= pin_nxt;
      signal_output_pin_oe_n_o <= oe_n_nxt;
    end
  end

endmodule

//--- som_mux_sva.sv
// Checker for the output source selection of the signal output mux.
`timescale 1ns/10ps
module som_mux_sva (
  // Clock and reset
  input wire logic        ref_clk_i,
  input wire logic        nrst_i,
  input wire logic        clk_en_i,
  // Register bus
  input wire logic        hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic        hready_i,
  // Sources and outputs
  input wire logic [7:0]  test_bus_i,
  input wire logic        coder_env_i,
  input wire logic        tx_serial_i,
  input wire logic        rx_regen_i,
  input wire logic        rx_serial_i,
  input wire logic        hs_tx_i,
  input wire logic        a_tx_carrier_i,
  input wire logic        rx_active_o,
  input wire logic        signal_output_pin_o,
  input wire logic        signal_output_pin_oe_n_o
);
  logic       wr_q;
  logic [7:0] wa_q;
  logic [3:0] s_q;
  logic [2:0] t_q;
  wire        pin_w = signal_output_pin_o;
  wire        oen_w = signal_output_pin_oe_n_o;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  // Shadow of the source and test bit fields, taken from the bus data phase.
  always @(posedge ref_clk_i) begin
    wa_q <= haddr_i[7:0];
    if (!nrst_i) begin
      wr_q <= 1'b0;
      s_q  <= 4'h0;
      t_q  <= 3'h0;
    end else if (clk_en_i) begin
      wr_q <= hsel_i && hready_i && htrans_i[1] && hwrite_i;
      if (wr_q && wa_q == 8'h58) begin
        s_q <= hwdata_i[3:0];
      end
      if (wr_q && wa_q == 8'h60) begin
        t_q <= hwdata_i[2:0];
      end
    end
  end
  AST_TRI: assert property (s_q == 4'h0 |=> oen_w)
    else $error("pin driven while tristate selected");
  AST_LVL: assert property (s_q inside {4'h1, 4'h2} |=> !oen_w && pin_w == $past(s_q[1]))
    else $error("constant level wrong");
  AST_TBUS: assert property (s_q == 4'h3 |=> pin_w == $past(test_bus_i[t_q]))
    else $error("test bus bit wrong");
  AST_ENV: assert property (s_q == 4'h4 |=> pin_w == $past(coder_env_i))
    else $error("coder envelope wrong");
  AST_TXS: assert property (s_q == 4'h5 |=> pin_w == $past(tx_serial_i))
    else $error("transmit stream wrong");
  AST_RXO: assert property (s_q == 4'h6 |=> pin_w == $past(rx_regen_i && rx_active_o))
    else $error("receiver output wrong");
  AST_RXS: assert property (s_q == 4'h7 |=> pin_w == $past(rx_serial_i))
    else $error("receive stream wrong");
  AST_HS: assert property (s_q == 4'h9 |=> !oen_w && pin_w == $past(hs_tx_i))
    else $error("high speed transmit wrong");
  AST_ATX: assert property (s_q == 4'hD |=> pin_w == $past(a_tx_carrier_i))
    else $error("type A transmit wrong");
endmodule
bind som_signal_output_mux som_mux_sva chk_u (.*);

//--- som_sam_model.sv
// Secure access module model listening on the signal output line.
`timescale 1ns/10ps
module som_sam_model (
  // Clock and pin
  input  wire logic ref_clk_i,
  input  wire logic pin_i,
  input  wire logic pin_oe_n_i,
  // Line level seen by the module
  output wire logic line_o
);
  logic last_r;
  always @(posedge ref_clk_i) begin
    if (!pin_oe_n_i) begin
      last_r <= pin_i;
    end
  end
  // The line has no pull, so a released line must not look like a stale copy.
  assign line_o = pin_oe_n_i ? ~last_r : pin_i;
endmodule

//--- som_signal_output_mux_tb.sv
// Testbench for the signal output mux and receiver select logic.
`timescale 1ns/10ps
module som_signal_output_mux_tb;
  logic        ref_clk_i, nrst_i, hsel_i, hwrite_i, e;
  logic [1:0]  htrans_i;
  logic [31:0] haddr_i, hwdata_i, rdata;
  logic [15:0] sv;
  logic [2:0]  ev;
  int          err_count, checks_done, c, k, b;
  logic        clk_en_i;
  wire [2:0]   hsize_i = 3'h2;
  wire [7:0]   test_bus_i = sv[3] ? 8'h20 : 8'hDF;
  wire [31:0]  hrdata_o;
  wire         hready_i, hreadyout_o, hresp_o, uart_in_o, rx_data_o, rx_active_o, line;
  wire         signal_output_pin_o, signal_output_pin_oe_n_o, coder_env_i, tx_serial_i;
  wire         rx_regen_i, rx_serial_i, hs_rx_i, hs_tx_i, hs_cmp_i, a_rx_carrier_i;
  wire         a_tx_carrier_i, a_rx_unfilt_i, a_env_unfilt_i, tx_done_i, bit_clk_i;
  wire         rx_frame_end_i, rx_pin_i, sig_in_env_i, analog_mod_i, sig_in_mod_i;
  // Each source sits on the bit of sv that matches its output code.
  assign {a_env_unfilt_i, a_rx_unfilt_i, a_tx_carrier_i, a_rx_carrier_i, sig_in_mod_i} = sv[15:11];
  assign {hs_cmp_i, hs_tx_i, hs_rx_i, rx_serial_i, rx_regen_i, tx_serial_i} = sv[10:5];
  assign {coder_env_i, analog_mod_i, sig_in_env_i, rx_pin_i} = {sv[4], sv[2:0]};
  assign {rx_frame_end_i, bit_clk_i, tx_done_i} = ev;
  assign hready_i = hreadyout_o;
  som_signal_output_mux dut_u (.*);
  som_sam_model sam_u (.ref_clk_i(ref_clk_i), .pin_i(signal_output_pin_o),
    .pin_oe_n_i(signal_output_pin_oe_n_o), .line_o(line));
  task results;
    $display("mismatches %0d comparisons %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task rdy;
    int n;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (hreadyout_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      results;
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i <= {24'h000000, a};
    hwrite_i <= w;
    rdy;
    htrans_i <= 2'h0;
    hsel_i <= 1'b0;
    hwdata_i <= d;
    rdy;
    rdata = hrdata_o;
  endtask
  task settle;
    repeat (2) @(posedge ref_clk_i);
    #1;
  endtask
  task pulse(input logic [2:0] m);
    @(posedge ref_clk_i);
    ev <= m;
    @(posedge ref_clk_i);
    ev <= 3'h0;
    settle;
  endtask
  task sweep(input logic act);
    for (c = 0; c < 16; c++) begin
      bus(1'b1, 8'h58, c);
      for (k = 0; k < 2; k++) begin
        @(posedge ref_clk_i);
        sv <= (k != 0) ? ~(16'h0001 << c) : (16'h0001 << c);
        e = (c == 2) || (k == 0 && c != 1 && c != 11 && (act || (c != 6 && c != 8 && c != 12)));
        settle;
        chk(signal_output_pin_oe_n_o, c == 0);
        if (c != 0) chk(line, e);
      end
    end
  endtask
  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    {nrst_i, hsel_i, htrans_i, haddr_i, hwrite_i, hwdata_i, sv, ev} = '0;
    clk_en_i = 1'b1;
    err_count = 0;
    checks_done = 0;
    repeat (3) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    bus(1'b0, 8'h5C, 0); chk(rdata, 32'h84);
    bus(1'b0, 8'h58, 0); chk(rdata, 32'h10);
    bus(1'b0, 8'h70, 0); chk(rdata, 32'h0);
    bus(1'b1, 8'h58, 32'hFF); bus(1'b0, 8'h58, 0); chk(rdata, 32'h3F);
    bus(1'b1, 8'h5C, 32'h5A); bus(1'b0, 8'h5C, 0); chk(rdata, 32'h5A);
    bus(1'b1, 8'h60, 32'h5);
    for (c = 0; c < 4; c++) begin
      bus(1'b1, 8'h5C, c << 6);
      b = (c == 3) ? 11 : c;
      for (k = 0; k < 2; k++) begin
        @(posedge ref_clk_i);
        sv <= (k != 0) ? ~(16'h0001 << b) : (16'h0001 << b);
        settle;
        chk(uart_in_o, c != 0 && k == 0);
      end
    end
    sweep(1'b0);
    bus(1'b1, 8'h5C, 32'h03);
    bus(1'b1, 8'h68, 32'h1);
    pulse(3'h1);
    @(posedge ref_clk_i);
    sv <= 16'h0001;
    pulse(3'h2); pulse(3'h2); chk(rx_active_o, 0);
    chk(rx_data_o, 0);
    pulse(3'h2); chk(rx_active_o, 1);
    chk(rx_data_o, 1);
    pulse(3'h4); chk(rx_active_o, 0);
    bus(1'b1, 8'h68, 32'h6); settle; chk(rx_active_o, 1);
    pulse(3'h4); chk(rx_active_o, 1);
    bus(1'b0, 8'h64, 0); chk(rdata, 32'h7);
    sweep(1'b1);
    @(posedge ref_clk_i);
    clk_en_i <= 1'b0;
    bus(1'b1, 8'h58, 32'h1);
    @(posedge ref_clk_i);
    clk_en_i <= 1'b1;
    bus(1'b0, 8'h58, 0); chk(rdata, 32'hF);
    results;
  end
endmodule
